/* File: inc/imx_pkg.sv */
package imx_pkg;
  localparam int          GR_WIDTH      = 64;
  localparam int          SIG_WIDTH     = 64;
  localparam int          EXP_WIDTH     = 17;
  localparam int          FR_WIDTH      = 82;
  localparam int          REG_IDX_WIDTH = 7;
  localparam int          IMM_WIDTH     = 8;
  localparam int          SIZE_WIDTH    = 2;
  localparam int          BITS_PER_BYTE = 8;
  localparam logic [16:0] INT_EXPONENT  = 17'h1003E;
  localparam logic        SIGN_POSITIVE = 1'b0;
  localparam logic [16:0] NATVAL_EXP    = 17'h1FFFE;
  localparam logic [63:0] NATVAL_SIG    = 64'h0000000000000000;
  localparam logic [6:0]  GR_ZERO       = 7'h00;
  localparam logic [6:0]  FR_ZERO       = 7'h00;
  localparam logic [6:0]  FR_ONE        = 7'h01;
  localparam logic [63:0] GR_RESET      = 64'h0000000000000000;
  localparam logic [81:0] FR_RESET      = 82'h0;

  typedef enum logic [2:0] {
    IMX_OP_NONE,
    IMX_OP_XMPY,
    IMX_OP_XOR,
    IMX_OP_ZXT
  } imx_op_e;

  typedef enum logic [1:0] {
    IMX_MUL_LOW,
    IMX_MUL_LOW_U,
    IMX_MUL_HIGH,
    IMX_MUL_HIGH_U
  } imx_mul_e;
endpackage

/* File: hw/imx_mul.sv */
`timescale 1ns/1ns
`default_nettype none
module imx_mul #(
  parameter int WIDTH = 64
) (
  input  wire logic [WIDTH-1:0] a_in,
  input  wire logic [WIDTH-1:0] b_in,
  input  wire logic             signed_in,
  input  wire logic             high_in,
  output logic      [WIDTH-1:0] half_out
);
  logic [2*WIDTH-1:0] prod_u;
  logic [2*WIDTH-1:0] prod_s;
  logic [2*WIDTH-1:0] prod;

  assign prod_u = {{WIDTH{1'b0}}, a_in} * {{WIDTH{1'b0}}, b_in};
  assign prod_s = $unsigned($signed({{WIDTH{a_in[WIDTH-1]}}, a_in}) *
                            $signed({{WIDTH{b_in[WIDTH-1]}}, b_in}));
  assign prod   = signed_in ? prod_s : prod_u;
  assign half_out = high_in ? prod[2*WIDTH-1:WIDTH] : prod[WIDTH-1:0];
endmodule
`default_nettype wire

/* File: hw/imx_zext.sv */
`timescale 1ns/1ns
`default_nettype none
module imx_zext #(
  parameter int WIDTH = 64
) (
  input  wire logic [WIDTH-1:0] src_in,
  input  wire logic [1:0]       size_in,
  output logic      [WIDTH-1:0] res_out
);
  logic [WIDTH-1:0] mask;

  always_comb begin
    case (size_in)
      2'h0:    mask = {{(WIDTH-8){1'b0}}, {8{1'b1}}};
      2'h1:    mask = {{(WIDTH-16){1'b0}}, {16{1'b1}}};
      2'h2:    mask = {{(WIDTH-32){1'b0}}, {32{1'b1}}};
      default: mask = {WIDTH{1'b1}};
    endcase
  end
  assign res_out = src_in & mask;
endmodule
`default_nettype wire

/* File: hw/imx_top.sv */
`timescale 1ns/1ns
`default_nettype none
module imx_top #(
  parameter int GRW = 64
) (
  input  wire logic                       clk_in,
  input  wire logic                       reset_in,
  input  wire logic                       issue_in,
  input  wire imx_pkg::imx_op_e           op_in,
  input  wire imx_pkg::imx_mul_e          mul_form_in,
  input  wire logic                       qualifying_predicate_in,
  input  wire logic                       immediate_operand_form_in,
  input  wire logic [7:0]                 imm_in,
  input  wire logic [1:0]                 zext_size_in,
  input  wire logic [6:0]                 dest_in,
  input  wire logic [GRW-1:0]             general_register_a_in,
  input  wire logic                       general_register_a_nat_in,
  input  wire logic [GRW-1:0]             general_register_b_in,
  input  wire logic                       general_register_b_nat_in,
  input  wire logic [81:0]                float_register_a_in,
  input  wire logic [81:0]                float_register_b_in,
  output logic                            gr_write_out,
  output logic [6:0]                      gr_dest_out,
  output logic [GRW-1:0]                  gr_data_out,
  output logic                            gr_nat_out,
  output logic                            fr_write_out,
  output logic [6:0]                      fr_dest_out,
  output logic [81:0]                     fr_data_out,
  output logic                            fault_out
);
  logic [GRW-1:0] xor_op1;
  logic           xor_nat1;
  logic [GRW-1:0] xor_res;
  logic           xor_nat;
  logic [GRW-1:0] zext_res;
  logic [63:0]    mul_half;
  logic           mul_signed;
  logic           mul_high;
  logic           fa_natval;
  logic           fb_natval;
  logic [81:0]    mul_fr;
  logic           is_mul;
  logic           is_gr_op;
  logic           live;
  logic           gr_fault;
  logic           fr_fault;
  logic           any_fault;
  logic           next_gr_write;
  logic           next_fr_write;
  logic [GRW-1:0] next_gr_data;
  logic           next_gr_nat;

  assign is_mul   = (op_in == imx_pkg::IMX_OP_XMPY);
  assign is_gr_op = (op_in == imx_pkg::IMX_OP_XOR) ||
                    (op_in == imx_pkg::IMX_OP_ZXT);
  assign live     = issue_in && qualifying_predicate_in;

  assign mul_signed = (mul_form_in != imx_pkg::IMX_MUL_HIGH_U);
  assign mul_high   = (mul_form_in == imx_pkg::IMX_MUL_HIGH) ||
                      (mul_form_in == imx_pkg::IMX_MUL_HIGH_U);

  imx_mul #(
    .WIDTH(imx_pkg::SIG_WIDTH)
  ) u_mul (
    .a_in      (float_register_a_in[63:0]),
    .b_in      (float_register_b_in[63:0]),
    .signed_in (mul_signed),
    .high_in   (mul_high),
    .half_out  (mul_half)
  );

  assign fa_natval = (float_register_a_in[80:64] == imx_pkg::NATVAL_EXP) &&
                     (float_register_a_in[63:0] == imx_pkg::NATVAL_SIG) &&
                     !float_register_a_in[81];
  assign fb_natval = (float_register_b_in[80:64] == imx_pkg::NATVAL_EXP) &&
                     (float_register_b_in[63:0] == imx_pkg::NATVAL_SIG) &&
                     !float_register_b_in[81];
  assign mul_fr = (fa_natval || fb_natval) ?
                  {imx_pkg::SIGN_POSITIVE, imx_pkg::NATVAL_EXP,
                   imx_pkg::NATVAL_SIG} :
                  {imx_pkg::SIGN_POSITIVE, imx_pkg::INT_EXPONENT, mul_half};

  assign xor_op1  = immediate_operand_form_in ?
                    {{(GRW-8){imm_in[7]}}, imm_in} : general_register_a_in;
  assign xor_nat1 = immediate_operand_form_in ? 1'b0 :
                    general_register_a_nat_in;
  assign xor_res  = xor_op1 ^ general_register_b_in;
  assign xor_nat  = xor_nat1 | general_register_b_nat_in;

  imx_zext #(
    .WIDTH(GRW)
  ) u_zext (
    .src_in  (general_register_b_in),
    .size_in (zext_size_in),
    .res_out (zext_res)
  );

  assign gr_fault  = is_gr_op && (dest_in == imx_pkg::GR_ZERO);
  assign fr_fault  = is_mul && ((dest_in == imx_pkg::FR_ZERO) ||
                                (dest_in == imx_pkg::FR_ONE));
  assign any_fault = live && (gr_fault || fr_fault);

  assign next_gr_write = live && is_gr_op && !gr_fault;
  assign next_fr_write = live && is_mul && !fr_fault;
  assign next_gr_data  = (op_in == imx_pkg::IMX_OP_XOR) ? xor_res : zext_res;
  assign next_gr_nat   = (op_in == imx_pkg::IMX_OP_XOR) ? xor_nat :
                         general_register_b_nat_in;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      gr_write_out <= 1'b0;
      fr_write_out <= 1'b0;
      fault_out    <= 1'b0;
    end else begin
      gr_write_out <= next_gr_write;
      fr_write_out <= next_fr_write;
      fault_out    <= any_fault;
    end
  end

  // data is qualified by the write strobes, so it loads every cycle
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      gr_dest_out <= 7'h00;
      gr_data_out <= {GRW{1'b0}};
      gr_nat_out  <= 1'b0;
      fr_dest_out <= 7'h00;
      fr_data_out <= imx_pkg::FR_RESET;
    end else begin
      gr_dest_out <= dest_in;
      gr_data_out <= next_gr_data;
      gr_nat_out  <= next_gr_nat;
      fr_dest_out <= dest_in;
      fr_data_out <= mul_fr;
    end
  end

  AST_MUL_EXP: assert property (@(posedge clk_in) disable iff (reset_in)
    fr_write_out && !(fr_data_out[80:64] == imx_pkg::NATVAL_EXP) |->
    fr_data_out[80:64] == 17'h1003E && !fr_data_out[81])
    else $error("multiply exponent or sign wrong");
  AST_PRED_OFF: assert property (@(posedge clk_in) disable iff (reset_in)
    !qualifying_predicate_in |=> !gr_write_out && !fr_write_out && !fault_out)
    else $error("false predicate had an effect");
  AST_R0_FAULT: assert property (@(posedge clk_in) disable iff (reset_in)
    live && is_gr_op && dest_in == 7'h00 |=> fault_out && !gr_write_out)
    else $error("r0 write not faulted");
  AST_F01_FAULT: assert property (@(posedge clk_in) disable iff (reset_in)
    live && is_mul && dest_in < 7'h02 |=> fault_out && !fr_write_out)
    else $error("f0 or f1 write not faulted");
  AST_XOR_VAL: assert property (@(posedge clk_in) disable iff (reset_in)
    live && op_in == imx_pkg::IMX_OP_XOR && dest_in != 7'h00 |=>
    gr_write_out && gr_data_out == (($past(immediate_operand_form_in) ?
    {{(GRW-8){$past(imm_in[7])}}, $past(imm_in)} :
    $past(general_register_a_in)) ^ $past(general_register_b_in)))
    else $error("xor result wrong");
  AST_XOR_IMM_NAT: assert property (@(posedge clk_in) disable iff (reset_in)
    live && op_in == imx_pkg::IMX_OP_XOR && immediate_operand_form_in |=>
    gr_nat_out == $past(general_register_b_nat_in))
    else $error("immediate xor deferral wrong");
  AST_XOR_NAT: assert property (@(posedge clk_in) disable iff (reset_in)
    live && op_in == imx_pkg::IMX_OP_XOR && general_register_b_nat_in |=>
    gr_nat_out)
    else $error("xor deferral lost");
  AST_ZXT_NAT: assert property (@(posedge clk_in) disable iff (reset_in)
    live && op_in == imx_pkg::IMX_OP_ZXT |=>
    gr_nat_out == $past(general_register_b_nat_in))
    else $error("zero-extend deferral not copied");
  AST_ZXT_BYTE: assert property (@(posedge clk_in) disable iff (reset_in)
    live && op_in == imx_pkg::IMX_OP_ZXT && zext_size_in == 2'h0 |=>
    gr_data_out[GRW-1:8] == '0)
    else $error("zero-extend left high bits");
  AST_NATVAL: assert property (@(posedge clk_in) disable iff (reset_in)
    live && is_mul && fa_natval && dest_in > 7'h01 |=>
    fr_data_out[80:64] == imx_pkg::NATVAL_EXP && fr_data_out[63:0] == '0)
    else $error("deferred source not propagated");
  AST_WR_EXCL: assert property (@(posedge clk_in)
    disable iff (reset_in) fault_out |-> !gr_write_out && !fr_write_out)
    else $error("fault and write together");
  AST_IDLE: assert property (@(posedge clk_in)
    disable iff (reset_in)
    !issue_in |=> !gr_write_out && !fr_write_out && !fault_out)
    else $error("write without an issued op");
  AST_GR_DEST: assert property (@(posedge clk_in)
    disable iff (reset_in) live && is_gr_op && dest_in != 7'h00 |=>
    gr_write_out && !fault_out && gr_dest_out == $past(dest_in))
    else $error("general register commit wrong");
  AST_FR_DEST: assert property (@(posedge clk_in)
    disable iff (reset_in) live && is_mul && dest_in > 7'h01 |=>
    fr_write_out && !fault_out && fr_dest_out == $past(dest_in))
    else $error("float register commit wrong");
  AST_XOR_REG_NAT: assert property (@(posedge clk_in)
    disable iff (reset_in)
    live && op_in == imx_pkg::IMX_OP_XOR && !immediate_operand_form_in |=>
    gr_nat_out == ($past(general_register_a_nat_in) |
                   $past(general_register_b_nat_in)))
    else $error("register xor deferral wrong");
  AST_ZXT_HALF: assert property (@(posedge clk_in)
    disable iff (reset_in)
    live && op_in == imx_pkg::IMX_OP_ZXT && zext_size_in == 2'h1 |=>
    gr_data_out[GRW-1:16] == '0 &&
    gr_data_out[15:0] == $past(general_register_b_in[15:0]))
    else $error("zero-extend half wrong");
  AST_ZXT_WORD: assert property (@(posedge clk_in)
    disable iff (reset_in)
    live && op_in == imx_pkg::IMX_OP_ZXT && zext_size_in == 2'h2 |=>
    gr_data_out[GRW-1:32] == '0 &&
    gr_data_out[31:0] == $past(general_register_b_in[31:0]))
    else $error("zero-extend word wrong");
  AST_MUL_ZERO: assert property (@(posedge clk_in)
    disable iff (reset_in)
    live && is_mul && float_register_a_in[63:0] == '0 |=>
    fr_data_out[63:0] == '0)
    else $error("product of zero not zero");
  AST_MUL_LOW_ONE: assert property (@(posedge clk_in)
    disable iff (reset_in) live && is_mul && !mul_high &&
    float_register_b_in[63:0] == 64'h1 |=>
    fr_data_out[63:0] == $past(float_register_a_in[63:0]))
    else $error("low product by one wrong");
  AST_MUL_HIGH_ONE: assert property (@(posedge clk_in)
    disable iff (reset_in)
    live && is_mul && mul_form_in == imx_pkg::IMX_MUL_HIGH &&
    float_register_b_in[63:0] == 64'h1 |=>
    fr_data_out[63:0] == {64{$past(float_register_a_in[63])}})
    else $error("signed high product by one wrong");
  AST_MUL_HIGHU_ONE: assert property (@(posedge clk_in)
    disable iff (reset_in)
    live && is_mul && mul_form_in == imx_pkg::IMX_MUL_HIGH_U &&
    float_register_b_in[63:0] == 64'h1 |=>
    fr_data_out[63:0] == '0)
    else $error("unsigned high product by one wrong");

  COV_MUL: cover property (@(posedge clk_in) disable iff (reset_in)
    fr_write_out);
  COV_XOR: cover property (@(posedge clk_in) disable iff (reset_in)
    live && op_in == imx_pkg::IMX_OP_XOR && immediate_operand_form_in);
  COV_ZXT: cover property (@(posedge clk_in) disable iff (reset_in)
    live && op_in == imx_pkg::IMX_OP_ZXT);
  COV_FAULT: cover property (@(posedge clk_in) disable iff (reset_in)
    fault_out);
endmodule
`default_nettype wire

/* File: test/imx_top_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module imx_top_tb_top;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  issue = 1'b0;
  imx_pkg::imx_op_e      op = imx_pkg::IMX_OP_NONE;
  imx_pkg::imx_mul_e     form = imx_pkg::IMX_MUL_LOW;
  logic                  pred = 1'b1;
  logic                  immf = 1'b0;
  logic [7:0]            imm = 8'h00;
  logic [1:0]            size = 2'h0;
  logic [6:0]            dest = 7'h04;
  logic [63:0]           ga = 64'h0;
  logic [63:0]           gb = 64'h0;
  logic                  gan = 1'b0;
  logic                  gbn = 1'b0;
  logic [81:0]           fa = 82'h0;
  logic [81:0]           fb = 82'h0;
  logic                  gw, gn, fw, flt;
  logic [6:0]            gd, fd;
  logic [63:0]           gdat;
  logic [81:0]           fdat;
  logic [127:0]          pu, ps;
  int                    err_total = 0;
  int                    n_checks = 0;

  imx_top u_dut (.clk_in(clk), .reset_in(rst), .issue_in(issue),
    .op_in(op), .mul_form_in(form), .qualifying_predicate_in(pred),
    .immediate_operand_form_in(immf), .imm_in(imm), .zext_size_in(size),
    .dest_in(dest), .general_register_a_in(ga),
    .general_register_a_nat_in(gan), .general_register_b_in(gb),
    .general_register_b_nat_in(gbn), .float_register_a_in(fa),
    .float_register_b_in(fb), .gr_write_out(gw), .gr_dest_out(gd),
    .gr_data_out(gdat), .gr_nat_out(gn), .fr_write_out(fw),
    .fr_dest_out(fd), .fr_data_out(fdat), .fault_out(flt));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [81:0] e,
                     input logic [81:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one op taken at the next edge, strobes sampled once settled
  task automatic fire(input logic e_gw, input logic e_fw, input logic e_f);
    issue <= 1'b1;
    @(posedge clk);
    issue <= 1'b0;
    #1;
    chk("gr_write", 82'(e_gw), 82'(gw));
    chk("fr_write", 82'(e_fw), 82'(fw));
    chk("fault", 82'(e_f), 82'(flt));
  endtask

  task automatic t_mul();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      op <= imx_pkg::IMX_OP_XMPY; form <= imx_pkg::imx_mul_e'(i);
      dest <= 7'h02; pred <= 1'b1;
      fa <= {18'h0, 64'hFFFFFFFFFFFFFFFD};
      fb <= {18'h0, 64'h8000000000000005};
      pu = {64'h0, 64'hFFFFFFFFFFFFFFFD} * {64'h0, 64'h8000000000000005};
      ps = {{64{1'b1}}, 64'hFFFFFFFFFFFFFFFD} *
           {{64{1'b1}}, 64'h8000000000000005};
      fire(1'b0, 1'b1, 1'b0);
      chk("fr_dest", 82'h02, 82'(fd));
      chk("fr_data", {1'b0, 17'h1003E, (i == 3) ? pu[127:64] :
          (i == 2) ? ps[127:64] : ps[63:0]}, fdat);
    end
    // multiply by one shows each half and its sign handling
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      form <= imx_pkg::imx_mul_e'(i);
      fa <= {18'h0, 64'hFFFFFFFFFFFFFFFD}; fb <= {18'h0, 64'h1};
      fire(1'b0, 1'b1, 1'b0);
      chk("fr_one", {1'b0, 17'h1003E, (i == 3) ? 64'h0 :
          (i == 2) ? {64{1'b1}} : 64'hFFFFFFFFFFFFFFFD}, fdat);
    end
    // deferred source gives the deferred value
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      fa <= i ? 82'h0 : {1'b0, 17'h1FFFE, 64'h0};
      fb <= i ? {1'b0, 17'h1FFFE, 64'h0} : 82'h5;
      fire(1'b0, 1'b1, 1'b0);
      chk("fr_natval", {1'b0, 17'h1FFFE, 64'h0}, fdat);
    end
    $display("test multiply done");
  endtask

  task automatic t_xor();
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      op <= imx_pkg::IMX_OP_XOR; dest <= 7'h04; immf <= (i == 4);
      imm <= 8'h80; ga <= 64'h00FF00FF12345678;
      gb <= 64'h0F0F0F0F0F0F0F0F; gan <= i[0] | (i == 4); gbn <= i[1];
      fire(1'b1, 1'b0, 1'b0);
      chk("gr_dest", 82'h04, 82'(gd));
      chk("gr_data", 82'((i == 4) ? 64'hF0F0F0F0F0F0F08F :
          64'h0FF00FF01D3B5977), 82'(gdat));
      chk("gr_nat", 82'((i < 4) && (i != 0)), 82'(gn));
    end
    immf <= 1'b0;
    $display("test xor done");
  endtask

  task automatic t_zxt();
    logic [63:0] m;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      op <= imx_pkg::IMX_OP_ZXT; size <= 2'(i); dest <= 7'h7F;
      gb <= 64'h8877665544332211; gbn <= i[0];
      m = (i == 3) ? {64{1'b1}} : ((64'h1 << (8 << i)) - 64'h1);
      fire(1'b1, 1'b0, 1'b0);
      chk("zext_data", 82'(64'h8877665544332211 & m), 82'(gdat));
      chk("zext_nat", 82'(i[0]), 82'(gn));
    end
    $display("test zero extend done");
  endtask

  task automatic t_guard();
    @(posedge clk);
    op <= imx_pkg::IMX_OP_XOR; pred <= 1'b0; dest <= 7'h00;
    fire(1'b0, 1'b0, 1'b0);
    @(posedge clk);
    pred <= 1'b1;
    fire(1'b0, 1'b0, 1'b1);
    @(posedge clk);
    op <= imx_pkg::IMX_OP_ZXT;
    fire(1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      op <= imx_pkg::IMX_OP_XMPY; dest <= 7'(i);
      fire(1'b0, 1'b0, 1'b1);
    end
    $display("test guards done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    report_and_stop();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("reset_strobes", 82'h0, 82'({gw, fw, flt}));
    t_mul();
    t_xor();
    t_zxt();
    t_guard();
    report_and_stop();
  end
endmodule
`default_nettype wire
